// ==== control_mode_defs.svh ====
// Constants for the control mode pin select block
`ifndef CONTROL_MODE_DEFS_SVH
`define CONTROL_MODE_DEFS_SVH

// ----------------------------------------
// Serial frame layout
// ----------------------------------------
`define FRAME_BITS 5'h14
`define FRAME_ADDR_MSB 19
`define FRAME_ADDR_LSB 16
`define FRAME_DATA_MSB 15
`define FRAME_DATA_LSB 0

// ----------------------------------------
// Register map
// ----------------------------------------
`define CONFIG_WORD_D_ADDR 4'hd
`define CONFIG_WORD_D_RESET 16'h3fff
`define CONTROL_WORD_ADDR 4'h1
`define USER_REG_MASK 16'h6e0e
`define REG_RESET 16'h0000

// ----------------------------------------
// Control word field positions
// ----------------------------------------
`define CTL_RANGE_BIT 0
`define CTL_SWING_BIT 1
`define CTL_EDGE_BIT 2
`define CTL_DDR_BIT 3
`define CTL_CALIBRATION_DELAY_SELECT_BIT 4

`endif

// ==== control_mode_pkg.sv ====
// Types shared by the control mode pin select block
package control_mode_pkg;

   // ----------------------------------------
   // Three-state strap level
   // ----------------------------------------
   typedef enum logic [1:0] {
      LVL_LOW = 2'h0,
      LVL_HIGH = 2'h1,
      LVL_FLOAT = 2'h2
   } tri_level_t;

   // ----------------------------------------
   // Effective converter controls
   // ----------------------------------------
   typedef struct packed {
      logic range_wide;
      logic swing_high;
      logic edge_pos;
      logic ddr;
      logic calibration_delay_select_long;
   } ctrl_t;

   // ----------------------------------------
   // Register load progress, Gray coded
   // ----------------------------------------
   typedef enum logic [1:0] {
      CFG_IDLE = 2'b00,
      CFG_LOADING = 2'b01,
      CFG_READY = 2'b11,
      CFG_ERROR = 2'b10
   } cfg_state_t;

endpackage : control_mode_pkg

// ==== control_mode_pin_select.sv ====
// Control pin decode: strap mode or serial extended mode
`timescale 1ns/1ns

`include "control_mode_defs.svh"

module control_mode_pin_select
   import control_mode_pkg::*;
#(
   parameter int REG_WIDTH = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Strap pins, three-state levels
   input wire tri_level_t range_strap,
   input wire tri_level_t amplitude_select,
   input wire tri_level_t output_edge_select,
   input wire tri_level_t calibration_delay_select,
   // Serial clock, buffered from the amplitude pin
   input wire logic serial_clk,
   // Decoded controls
   output ctrl_t ctrl,
   output logic extended_mode,
   output logic [REG_WIDTH-1:0] config_word_d,
   output logic regs_all_written,
   output logic init_order_error,
   output cfg_state_t cfg_state
);

   // ----------------------------------------
   // Strap synchronisers
   // ----------------------------------------
   tri_level_t pin_raw [4];
   logic [1:0] pin_s1_r [4];
   logic [1:0] pin_s2_r [4];

   assign pin_raw[0] = range_strap;
   assign pin_raw[1] = amplitude_select;
   assign pin_raw[2] = output_edge_select;
   assign pin_raw[3] = calibration_delay_select;

   for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge ref_clk or posedge sys_rst) begin
         if (sys_rst) begin
            pin_s1_r[i] <= 2'h0;
            pin_s2_r[i] <= 2'h0;
         end else begin
            pin_s1_r[i] <= pin_raw[i];
            pin_s2_r[i] <= pin_s1_r[i];
         end
      end
   end

   logic ext_now;
   assign ext_now = (pin_s2_r[0] == LVL_FLOAT);

   // ----------------------------------------
   // Serial link domain
   // ----------------------------------------
   logic frame_rst;
   logic sdi;
   logic [4:0] bit_cnt_r;
   logic [18:0] shift_r;
   logic [19:0] word_r;
   logic word_tgl_r;

   // Chip select low selects; data bit is the edge pin level
   assign frame_rst = (calibration_delay_select != LVL_LOW);
   assign sdi = (output_edge_select == LVL_HIGH);

   always_ff @(posedge serial_clk or posedge frame_rst) begin
      if (frame_rst) begin
         bit_cnt_r <= 5'h0;
         shift_r <= 19'h0;
      end else if (bit_cnt_r != `FRAME_BITS) begin
         bit_cnt_r <= bit_cnt_r + 5'h1;
         shift_r <= {shift_r[17:0], sdi};
      end
   end

   // Last bit lands the word and flags it across
   always_ff @(posedge serial_clk or posedge sys_rst) begin
      if (sys_rst) begin
         word_r <= 20'h0;
         word_tgl_r <= 1'b0;
      end else if (!frame_rst && bit_cnt_r == `FRAME_BITS - 5'h1) begin
         word_r <= {shift_r, sdi};
         word_tgl_r <= ~word_tgl_r;
      end
   end

   // ----------------------------------------
   // Word crossing into ref_clk
   // ----------------------------------------
   logic tgl_s1_r;
   logic tgl_s2_r;
   logic tgl_s3_r;
   logic wr_pulse;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tgl_s1_r <= 1'b0;
         tgl_s2_r <= 1'b0;
         tgl_s3_r <= 1'b0;
      end else begin
         tgl_s1_r <= word_tgl_r;
         tgl_s2_r <= tgl_s1_r;
         tgl_s3_r <= tgl_s2_r;
      end
   end

   // Word is stable for a whole frame after the toggle
   assign wr_pulse = (tgl_s2_r ^ tgl_s3_r) && ext_now;

   localparam logic [15:0] USER_MASK = `USER_REG_MASK;

   logic [3:0] wr_addr;
   logic [REG_WIDTH-1:0] wr_data;
   logic wr_user;

   assign wr_addr = word_r[`FRAME_ADDR_MSB:`FRAME_ADDR_LSB];
   assign wr_data = word_r[`FRAME_DATA_MSB:`FRAME_DATA_LSB];
   assign wr_user = wr_pulse && USER_MASK[wr_addr];

   // ----------------------------------------
   // User registers
   // ----------------------------------------
   logic [REG_WIDTH-1:0] regs_r [16];
   logic [15:0] written_r;

   for (genvar j = 0; j < 16; j++) begin : g_reg
      always_ff @(posedge ref_clk or posedge sys_rst) begin
         if (sys_rst) begin
            regs_r[j] <= (j == `CONFIG_WORD_D_ADDR) ? `CONFIG_WORD_D_RESET : `REG_RESET;
            written_r[j] <= 1'b0;
         end else if (wr_user && wr_addr == 4'(j)) begin
            regs_r[j] <= wr_data;
            written_r[j] <= 1'b1;
         end
      end
   end

   logic all_written;
   assign all_written = &(written_r | ~USER_MASK);

   // ----------------------------------------
   // Load order tracking
   // ----------------------------------------
   logic d_bad;
   assign d_bad = wr_user && wr_addr == `CONFIG_WORD_D_ADDR
                  && !written_r[`CONFIG_WORD_D_ADDR]
                  && wr_data != `CONFIG_WORD_D_RESET;

   cfg_state_t state_r;
   cfg_state_t state_nxt;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         CFG_IDLE: begin
            if (d_bad) begin
               state_nxt = CFG_ERROR;
            end else if (wr_user) begin
               state_nxt = CFG_LOADING;
            end
         end
         CFG_LOADING: begin
            if (d_bad) begin
               state_nxt = CFG_ERROR;
            end else if (all_written) begin
               state_nxt = CFG_READY;
            end
         end
         CFG_READY: begin
            state_nxt = CFG_READY;
         end
         CFG_ERROR: begin
            state_nxt = CFG_ERROR;
         end
         default: begin
            state_nxt = CFG_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= CFG_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------
   // Effective controls
   // ----------------------------------------
   logic [REG_WIDTH-1:0] cw;
   ctrl_t ctrl_nxt;
   assign cw = regs_r[`CONTROL_WORD_ADDR];

   always_comb begin
      if (ext_now) begin
         ctrl_nxt.range_wide = cw[`CTL_RANGE_BIT];
         ctrl_nxt.swing_high = cw[`CTL_SWING_BIT];
         ctrl_nxt.edge_pos = cw[`CTL_EDGE_BIT];
         ctrl_nxt.ddr = cw[`CTL_DDR_BIT];
         ctrl_nxt.calibration_delay_select_long = cw[`CTL_CALIBRATION_DELAY_SELECT_BIT];
      end else begin
         ctrl_nxt.range_wide = (pin_s2_r[0] == LVL_HIGH);
         ctrl_nxt.swing_high = (pin_s2_r[1] == LVL_HIGH);
         ctrl_nxt.ddr = (pin_s2_r[2] == LVL_FLOAT);
         ctrl_nxt.edge_pos = (pin_s2_r[2] == LVL_HIGH);
         ctrl_nxt.calibration_delay_select_long = (pin_s2_r[3] == LVL_HIGH);
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl <= '0;
         extended_mode <= 1'b0;
      end else begin
         ctrl <= ctrl_nxt;
         extended_mode <= ext_now;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         config_word_d <= `CONFIG_WORD_D_RESET;
         regs_all_written <= 1'b0;
         init_order_error <= 1'b0;
      end else begin
         config_word_d <= regs_r[`CONFIG_WORD_D_ADDR];
         regs_all_written <= all_written;
         init_order_error <= (state_nxt == CFG_ERROR);
      end
   end

   assign cfg_state = state_r;

endmodule : control_mode_pin_select

// ==== control_mode_pin_select_properties.sv ====
// Port checks for the control mode pin select block
`timescale 1ns/1ns
module control_mode_pin_select_chk
   import control_mode_pkg::*;
#(
   parameter int REG_WIDTH = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Pins
   input wire tri_level_t range_strap,
   input wire tri_level_t amplitude_select,
   input wire tri_level_t output_edge_select,
   input wire tri_level_t calibration_delay_select,
   input wire logic serial_clk,
   // Outputs
   input wire ctrl_t ctrl,
   input wire logic extended_mode,
   input wire logic [REG_WIDTH-1:0] config_word_d,
   input wire logic regs_all_written,
   input wire logic init_order_error,
   input wire cfg_state_t cfg_state
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   logic [3:0] strap_cnt_r;
   wire strap_mode = range_strap != LVL_FLOAT;
   // Cycles spent in strap mode, saturating
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         strap_cnt_r <= 4'h0;
      end else if (extended_mode) begin
         strap_cnt_r <= 4'h0;
      end else if (strap_cnt_r != 4'hf) begin
         strap_cnt_r <= strap_cnt_r + 4'h1;
      end
   end
   // Straps held long enough to reach ctrl
   sequence straps_held;
      ($stable(range_strap) && $stable(amplitude_select) && $stable(output_edge_select)
         && $stable(calibration_delay_select))[*4];
   endsequence
   sequence strap_ready;
      straps_held ##0 strap_mode;
   endsequence
   chk_mode_follows: assert property (straps_held |-> extended_mode == !strap_mode)
      else $error("mode flag does not follow the mode strap");
   chk_range_map: assert property (strap_ready |-> ctrl.range_wide == (range_strap == LVL_HIGH))
      else $error("input range does not follow the mode strap");
   chk_swing_map: assert property (strap_ready ##0 amplitude_select != LVL_FLOAT
      |-> ctrl.swing_high == (amplitude_select == LVL_HIGH)) else $error("swing does not follow its strap");
   chk_edge_map: assert property (strap_ready ##0 output_edge_select != LVL_FLOAT
      |-> ctrl.edge_pos == (output_edge_select == LVL_HIGH) && !ctrl.ddr) else $error("edge select wrong");
   chk_ddr_float: assert property (strap_ready ##0 output_edge_select == LVL_FLOAT
      |-> ctrl.ddr && !ctrl.edge_pos) else $error("floating edge pin did not give double rate");
   chk_calibration_delay_select_map: assert property (strap_ready |-> ctrl.calibration_delay_select_long == (calibration_delay_select == LVL_HIGH))
      else $error("calibration delay does not follow its strap");
   chk_link_idle: assert property (strap_cnt_r == 4'hf |-> $stable(config_word_d) && $stable(regs_all_written))
      else $error("register changed while in strap mode");
   chk_error_held: assert property (init_order_error |=> init_order_error)
      else $error("order error flag dropped");
   chk_ready_held: assert property (cfg_state == CFG_READY |=> cfg_state == CFG_READY)
      else $error("ready state left");
endmodule : control_mode_pin_select_chk

bind control_mode_pin_select control_mode_pin_select_chk #(.REG_WIDTH(REG_WIDTH)) i_control_mode_pin_select_chk (
   .ref_clk, .sys_rst, .range_strap, .amplitude_select, .output_edge_select, .calibration_delay_select,
   .serial_clk, .ctrl, .extended_mode, .config_word_d, .regs_all_written, .init_order_error, .cfg_state);

// ==== host_link_model.sv ====
// Host side of the serial link: writes whole frames
`timescale 1ns/1ns
module host_link_model
   import control_mode_pkg::*;
(
   // Link pins
   output logic serial_clk,
   output tri_level_t data_pin,
   output tri_level_t select_pin
);
   initial begin
      serial_clk = 1'h0;
      data_pin = LVL_HIGH;
      select_pin = LVL_HIGH;
   end
   // Address then data, MSB first; clock still between frames
   task automatic send(input logic [3:0] addr, input logic [15:0] data);
      logic [19:0] word;
      word = {addr, data};
      select_pin = LVL_LOW;
      for (int i = 19; i >= 0; i--) begin
         data_pin = word[i] ? LVL_HIGH : LVL_LOW;
         #7 serial_clk = 1'h1;
         #8 serial_clk = 1'h0;
      end
      select_pin = LVL_HIGH;
      data_pin = word[0] ? LVL_LOW : LVL_HIGH;
      #600;
   endtask : send
endmodule : host_link_model

// ==== control_mode_pin_select_tb.sv ====
// Self-checking bench for the control mode pin select block
`timescale 1ns/1ns
module control_mode_pin_select_tb;
   import control_mode_pkg::*;
   logic ref_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic ext_sel = 1'h0;
   logic serial_clk, extended_mode, regs_all_written, init_order_error;
   tri_level_t range_strap = LVL_LOW;
   tri_level_t amp_strap = LVL_LOW;
   tri_level_t edge_strap = LVL_LOW;
   tri_level_t cal_strap = LVL_LOW;
   tri_level_t amplitude_select, output_edge_select, calibration_delay_select, data_pin, select_pin;
   ctrl_t ctrl;
   logic [15:0] config_word_d;
   cfg_state_t cfg_state;
   int err_total = 0;
   int tests_run = 0;
   logic [3:0] others [7] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'he};
   always #50 ref_clk = ~ref_clk;
   // Pins carry straps or, once the host owns them, the link
   assign amplitude_select = tri_level_t'(ext_sel ? (serial_clk ? LVL_HIGH : LVL_LOW) : amp_strap);
   assign output_edge_select = tri_level_t'(ext_sel ? data_pin : edge_strap);
   assign calibration_delay_select = tri_level_t'(ext_sel ? select_pin : cal_strap);
   control_mode_pin_select i_control_mode_pin_select (.ref_clk, .sys_rst, .range_strap, .amplitude_select,
      .output_edge_select, .calibration_delay_select, .serial_clk, .ctrl, .extended_mode, .config_word_d,
      .regs_all_written, .init_order_error, .cfg_state);
   host_link_model i_host_link_model (.serial_clk, .data_pin, .select_pin);
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      tests_run++;
      if (seen !== want) begin
         err_total++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic settle;
      repeat (4) @(negedge ref_clk);
   endtask : settle
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      i_host_link_model.send(a, d);
      @(negedge ref_clk);
   endtask : wr
   task automatic stop_test;
      $display("Mismatches %0d, comparisons %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   initial begin
      #200000;
      err_total++;
      stop_test();
   end
   initial begin
      repeat (16) @(negedge ref_clk);
      sys_rst = 1'h0;
      check(16'({ctrl, extended_mode, cfg_state}), 16'h0000);
      check(config_word_d, 16'h3fff);
      for (int i = 0; i < 6; i++) begin
         range_strap = tri_level_t'(i % 2);
         amp_strap = tri_level_t'(i % 2);
         cal_strap = tri_level_t'(1 - i % 2);
         edge_strap = tri_level_t'(i / 2);
         settle();
         check(16'(ctrl), 16'({i % 2 == 1, i % 2 == 1, i / 2 == 1, i / 2 == 2, i % 2 == 0}));
         check(16'(extended_mode), 16'h0000);
      end
      ext_sel = 1'h1;
      wr(4'hd, 16'h1234);
      check(config_word_d, 16'h3fff);
      range_strap = LVL_FLOAT;
      settle();
      check(16'(extended_mode), 16'h0001);
      check(16'(ctrl), 16'h0000);
      wr(4'hd, 16'h3fff);
      foreach (others[k]) wr(others[k], 16'h0000);
      check(16'({regs_all_written, init_order_error, cfg_state}), 16'({2'h2, CFG_READY}));
      wr(4'h1, 16'h000b);
      check(16'(ctrl), 16'h001a);
      wr(4'h1, 16'h0014);
      check(16'(ctrl), 16'h0005);
      wr(4'hd, 16'h1234);
      check(config_word_d, 16'h1234);
      sys_rst = 1'h1;
      repeat (2) @(negedge ref_clk);
      sys_rst = 1'h0;
      check(config_word_d, 16'h3fff);
      settle();
      wr(4'hd, 16'h0000);
      foreach (others[k]) wr(others[k], 16'h0000);
      check(16'({init_order_error, cfg_state}), 16'({1'h1, CFG_ERROR}));
      stop_test();
   end
endmodule : control_mode_pin_select_tb
